// ---- hdl/mbpi_defs.vh ----
// mbpi_defs.vh: constants for the host bus pin interface
// assumes inclusion by bare name from the decode and top design files
`ifndef MBPI_DEFS_VH
`define MBPI_DEFS_VH

// ----------------------------------------------------------------
// host bus types, two bits
// ----------------------------------------------------------------
`define MBPI_HOST_W          2
`define MBPI_HOST_WR_RD      2'h0
`define MBPI_HOST_RW_E       2'h1
`define MBPI_HOST_RW_DS      2'h2
`define MBPI_HOST_WR_FETCH   2'h3

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define MBPI_PORT_W          8
`define MBPI_ADDR_W          16
`define MBPI_ADDR_RST        16'h0000
`define MBPI_DATA_RST        8'h00
`define MBPI_SYNC_RST        1'h1

// address strobe edge select field position in config
`define MBPI_AS_RISE_BIT     0

`endif

// ---- hdl/mbpi_sync.v ----
// mbpi_sync.v: two-stage synchroniser for a vector of pin inputs
// assumes asynchronous pins; rst is asynchronous active high
`timescale 1ns/1ns

module mbpi_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input  wire         mclk,
  input  wire         rst,
  // data
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule // mbpi_sync

// ---- hdl/mbpi_decode.v ----
// mbpi_decode.v: turns raw control levels into read/write qualifiers
// assumes synchronised control inputs on the mclk domain
`timescale 1ns/1ns
`include "mbpi_defs.vh"

module mbpi_decode (
  // configuration
  input  wire [`MBPI_HOST_W-1:0] host_type,
  // synchronised control pins
  input  wire                    write_ctl,
  input  wire                    read_ctl,
  // qualified cycle
  output reg                     rd_active,
  output reg                     wr_active
);

  always @* begin
    rd_active = 1'b0;
    wr_active = 1'b0;
    case (host_type)
      `MBPI_HOST_WR_RD: begin
        // separate active low strobes
        wr_active = ~write_ctl;
        rd_active = ~read_ctl;
      end
      `MBPI_HOST_RW_E: begin
        // bus phase clock high qualifies the cycle
        rd_active = write_ctl & read_ctl;
        wr_active = ~write_ctl & read_ctl;
      end
      `MBPI_HOST_RW_DS: begin
        rd_active = write_ctl & ~read_ctl;
        wr_active = ~write_ctl & ~read_ctl;
      end
      `MBPI_HOST_WR_FETCH: begin
        // fetch strobe acts as the read on this pin
        wr_active = ~write_ctl;
        rd_active = ~read_ctl;
      end
      default: begin
        rd_active = 1'b0;
        wr_active = 1'b0;
      end
    endcase
  end

endmodule // mbpi_decode

// ---- hdl/mbpi_top.v ----
// mbpi_top.v: host address/data bus pin interface of a memory peripheral
// assumes host pins are asynchronous to mclk and a single clock domain;
// select and read data come from internal decode logic on mclk
`timescale 1ns/1ns
`include "mbpi_defs.vh"

module mbpi_top (
  // clock and reset
  input  wire                    mclk,
  input  wire                    rst,
  // host pins
  input  wire                    reset_n,
  input  wire [7:0]              low_addr_data_port_i,
  output reg  [7:0]              low_addr_data_port_o,
  output reg                     low_addr_data_port_oe,
  input  wire [7:0]              high_addr_data_port_i,
  output reg  [7:0]              high_addr_data_port_o,
  output reg                     high_addr_data_port_oe,
  input  wire                    write_control_pin,
  input  wire                    read_control_pin,
  input  wire                    fetch_select_pin,
  input  wire                    address_valid_strobe,
  // configuration
  input  wire [`MBPI_HOST_W-1:0] host_type,
  input  wire                    as_rising,
  input  wire                    fetch_is_strobe,
  // internal decode side
  input  wire                    block_select,
  input  wire [7:0]              rd_data,
  input  wire [7:0]              rd_data_hi,
  input  wire                    wide_bus,
  input  wire                    flash_busy,
  // to programmable logic array
  output reg  [15:0]             pla_addr,
  output reg                     pla_write_ctl,
  output reg                     pla_read_ctl,
  output reg                     pla_fetch_n,
  output reg                     pla_general_in,
  output reg                     pla_rd_cycle,
  output reg                     pla_wr_cycle,
  output reg  [7:0]              wr_data,
  output reg                     wr_strobe,
  output reg                     flash_abort,
  output reg                     dev_reset
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [7:0] lo_s;
  wire [7:0] hi_s;
  wire [4:0] ctl_s;
  wire       wr_pin_s;
  wire       rd_pin_s;
  wire       fetch_s;
  wire       as_s;
  wire       rstn_s;

  mbpi_sync #(.W(8), .RST_VAL(8'h00)) u_sync_lo (
    .mclk (mclk),
    .rst  (rst),
    .din  (low_addr_data_port_i),
    .dout (lo_s)
  );

  mbpi_sync #(.W(8), .RST_VAL(8'h00)) u_sync_hi (
    .mclk (mclk),
    .rst  (rst),
    .din  (high_addr_data_port_i),
    .dout (hi_s)
  );

  // strobe resets low and control pins high, matching as_d_ff and the idle
  // levels of every host type except type 1, whose read pin idles low, so no false edge follows release;
  // reset_n resets low so the device starts held in reset
  mbpi_sync #(.W(5), .RST_VAL(5'h07)) u_sync_ctl (
    .mclk (mclk),
    .rst  (rst),
    .din  ({reset_n, address_valid_strobe, fetch_select_pin, read_control_pin, write_control_pin}),
    .dout (ctl_s)
  );

  assign wr_pin_s = ctl_s[0];
  assign rd_pin_s = ctl_s[1];
  assign fetch_s  = ctl_s[2];
  assign as_s     = ctl_s[3];
  assign rstn_s   = ctl_s[4];

  // ----------------------------------------------------------------
  // cycle qualification
  // ----------------------------------------------------------------
  wire rd_q;
  wire wr_q;

  mbpi_decode u_decode (
    .host_type (host_type),
    .write_ctl (wr_pin_s),
    .read_ctl  (rd_pin_s),
    .rd_active (rd_q),
    .wr_active (wr_q)
  );

  // a fetch strobe used for code only also counts as a read
  wire fetch_rd = fetch_is_strobe & ~fetch_s;
  wire rd_any   = rd_q | fetch_rd;

  // ----------------------------------------------------------------
  // address strobe edge detect
  // ----------------------------------------------------------------
  reg  as_d_ff;
  wire as_edge;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      as_d_ff <= 1'b0;
    end else begin
      as_d_ff <= as_s;
    end
  end

  // rising edge for address strobe hosts, falling for latch enable
  assign as_edge = as_rising ? (as_s & ~as_d_ff) : (~as_s & as_d_ff);

  // ----------------------------------------------------------------
  // address latch and logic array feed
  // ----------------------------------------------------------------
  wire dev_rst = ~rstn_s;
  reg  wr_q_d_ff;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pla_addr       <= `MBPI_ADDR_RST;
      pla_write_ctl  <= `MBPI_SYNC_RST;
      pla_read_ctl   <= `MBPI_SYNC_RST;
      pla_fetch_n    <= `MBPI_SYNC_RST;
      pla_general_in <= 1'b0;
      pla_rd_cycle   <= 1'b0;
      pla_wr_cycle   <= 1'b0;
      wr_data        <= `MBPI_DATA_RST;
      wr_strobe      <= 1'b0;
      wr_q_d_ff      <= 1'b0;
    end else if (dev_rst) begin
      // external reset pin returns the interface state
      pla_addr       <= `MBPI_ADDR_RST;
      pla_rd_cycle   <= 1'b0;
      pla_wr_cycle   <= 1'b0;
      pla_write_ctl  <= wr_pin_s;
      pla_read_ctl   <= rd_pin_s;
      pla_fetch_n    <= `MBPI_SYNC_RST;
      pla_general_in <= 1'b0;
      wr_data        <= `MBPI_DATA_RST;
      wr_strobe      <= 1'b0;
      wr_q_d_ff      <= 1'b0;
    end else begin
      if (as_edge) begin
        pla_addr <= {hi_s, lo_s};
      end
      pla_write_ctl  <= wr_pin_s;
      pla_read_ctl   <= rd_pin_s;
      pla_fetch_n    <= fetch_is_strobe ? fetch_s : 1'b1;
      pla_general_in <= fetch_is_strobe ? 1'b0 : fetch_s;
      pla_rd_cycle   <= rd_any;
      pla_wr_cycle   <= wr_q;
      wr_q_d_ff      <= wr_q;
      // data is taken as the write qualifier ends
      wr_strobe      <= wr_q_d_ff & ~wr_q;
      if (wr_q) begin
        wr_data <= lo_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data drivers
  // ----------------------------------------------------------------
  // enable follows the synchronised read, so it lags the pin by
  // about three mclk periods; slow hosts only
  wire drive_en = rd_any & block_select & ~dev_rst;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_addr_data_port_o   <= `MBPI_DATA_RST;
      high_addr_data_port_o  <= `MBPI_DATA_RST;
      low_addr_data_port_oe  <= 1'b0;
      high_addr_data_port_oe <= 1'b0;
    end else begin
      low_addr_data_port_o   <= rd_data;
      high_addr_data_port_o  <= rd_data_hi;
      low_addr_data_port_oe  <= drive_en;
      // high port carries data only for a sixteen bit data bus
      high_addr_data_port_oe <= drive_en & wide_bus;
    end
  end

  // ----------------------------------------------------------------
  // reset distribution and flash abort
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      dev_reset   <= 1'b1;
      flash_abort <= 1'b0;
    end else begin
      dev_reset   <= dev_rst;
      flash_abort <= dev_rst & flash_busy;
    end
  end

endmodule // mbpi_top

// ---- verif/mbpi_props.sv ----
// mbpi_props.sv: port assertions for mbpi_top
// assumes config inputs only change while rst is high
`timescale 1ns/1ns
module mbpi_props (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // inputs
  input wire logic        reset_n,
  input wire logic        address_valid_strobe,
  input wire logic        write_control_pin,
  input wire logic        block_select,
  input wire logic [7:0]  rd_data,
  input wire logic        flash_busy,
  input wire logic        fetch_is_strobe,
  // outputs
  input wire logic        low_addr_data_port_oe,
  input wire logic [7:0]  low_addr_data_port_o,
  input wire logic        high_addr_data_port_oe,
  input wire logic [15:0] pla_addr,
  input wire logic        pla_write_ctl,
  input wire logic        pla_general_in,
  input wire logic        pla_fetch_n,
  input wire logic        pla_wr_cycle,
  input wire logic        wr_strobe,
  input wire logic        flash_abort,
  input wire logic        dev_reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // cycles since the strobe pin last moved, saturating
  logic [2:0] quiet_ff;
  always @(posedge mclk or posedge rst)
    if (rst) quiet_ff <= 3'h0;
    else if ($changed(address_valid_strobe)) quiet_ff <= 3'h0;
    else if (quiet_ff != 3'h7) quiet_ff <= quiet_ff + 3'h1;
  sequence ctl_settled;
    $stable(write_control_pin) [*5];
  endsequence
  sequence busy_in_reset;
    (!reset_n && flash_busy) [*4];
  endsequence
  chk_addr_on_strobe: assert property ($changed(pla_addr) && !dev_reset && !$past(dev_reset) |-> quiet_ff < 3'h6)
    else $error("address moved without a strobe");
  chk_oe_select: assert property (low_addr_data_port_oe |-> $past(block_select))
    else $error("low port driven while unselected");
  chk_oe_data: assert property (low_addr_data_port_oe |-> low_addr_data_port_o == $past(rd_data))
    else $error("low port data not read data");
  chk_high_oe: assert property (high_addr_data_port_oe |-> low_addr_data_port_oe)
    else $error("high port driven alone");
  chk_ctl_follow: assert property (ctl_settled |-> pla_write_ctl == write_control_pin)
    else $error("write control level not passed on");
  chk_reset_quiet: assert property (dev_reset && $past(dev_reset) |-> !low_addr_data_port_oe && pla_addr == 16'h0000)
    else $error("outputs active during reset");
  chk_abort_reset: assert property (busy_in_reset |-> flash_abort)
    else $error("flash not aborted in reset");
  chk_wr_pulse: assert property (wr_strobe |-> ($past(pla_wr_cycle) || $past(pla_wr_cycle, 2)) ##1 !wr_strobe)
    else $error("write strobe without write or too long");
  chk_fetch_cfg: assert property (fetch_is_strobe |-> !pla_general_in)
    else $error("general input active in fetch mode");
  chk_general_cfg: assert property (!fetch_is_strobe |-> pla_fetch_n)
    else $error("fetch strobe active in general mode");
endmodule // mbpi_props

bind mbpi_top mbpi_props u_props (.mclk, .rst, .reset_n, .address_valid_strobe, .write_control_pin, .block_select,
  .rd_data, .flash_busy, .fetch_is_strobe, .low_addr_data_port_oe, .low_addr_data_port_o, .high_addr_data_port_oe,
  .pla_addr, .pla_write_ctl, .pla_general_in, .pla_fetch_n, .pla_wr_cycle, .wr_strobe, .flash_abort, .dev_reset);

// ---- verif/mbpi_host.sv ----
// mbpi_host.sv: behavioural 8-bit host on the pin side
// assumes the bench passes the same host type as the device config
`timescale 1ns/1ns
module mbpi_host (
  // clock and device drive
  input wire logic       mclk,
  input wire logic [7:0] dev_lo,
  input wire logic       dev_lo_oe,
  // host pins
  output logic [7:0]     lo_pin,
  output logic [7:0]     hi_pin,
  output logic           wr_pin,
  output logic           rd_pin,
  output logic           as_pin
);
  logic [7:0] lo_drv = 8'h00;
  logic [7:0] lo_last = 8'h00;
  logic       lo_en = 1'b0;
  initial {hi_pin, as_pin, wr_pin, rd_pin} = {8'h00, 3'h3};
  // bus driven by neither host nor device shows the inverse of its last value, so stale data cannot show
  always @* lo_pin = lo_en ? lo_drv : (dev_lo_oe ? dev_lo : ~lo_last);
  always @(posedge mclk) lo_last <= lo_pin;
  // {wr_pin, rd_pin} for idle (0), read (1), write (2)
  function automatic logic [1:0] pins(input logic [1:0] t, input int k);
    if (k == 1) return (t == 2'h1) ? 2'h3 : 2'h2;
    if (k == 2) return (t == 2'h2) ? 2'h0 : 2'h1;
    return (t == 2'h1) ? 2'h2 : 2'h3;
  endfunction
  // park the control pins at the idle level of host type t
  task automatic idle(input logic [1:0] t);
    {wr_pin, rd_pin} = pins(t, 0);
  endtask
  // low port carries A0-7 or data, high port A8-15
  task automatic bus(input logic [1:0] t, input logic [15:0] a, input int k, input logic [7:0] d);
    @(posedge mclk) #2;
    {hi_pin, lo_drv} = a;
    lo_en = 1'b1;
    as_pin = 1'b1;
    repeat (4) @(posedge mclk);
    #2 as_pin = 1'b0;
    repeat (5) @(posedge mclk);
    #2 lo_en = (k == 2);
    lo_drv = d;
    {wr_pin, rd_pin} = pins(t, k);
    repeat (8) @(posedge mclk);
    #2 {wr_pin, rd_pin} = pins(t, 0);
    repeat (2) @(posedge mclk);
    #2 lo_en = 1'b0;
  endtask
endmodule // mbpi_host

// ---- verif/testbench.sv ----
// testbench.sv: self-checking bench for mbpi_top
// assumes host model mbpi_host and the bound checker
`timescale 1ns/1ns
module testbench;
  logic mclk = 0, rst = 1, reset_n = 0, as_rising = 1, fetch_is_strobe = 0, fpin = 1;
  logic block_select = 0, wide_bus = 0, flash_busy = 0;
  logic [1:0] host_type = 2'h0;
  logic [7:0] rd_data = 8'h00, rd_data_hi = 8'h00, lo_pin, hi_pin, lo_o, hi_o, wr_data;
  logic [15:0] pla_addr, a;
  logic wr_pin, rd_pin, as_pin, lo_oe, hi_oe, pla_write_ctl, pla_read_ctl, pla_fetch_n, pla_general_in;
  logic pla_rd_cycle, pla_wr_cycle, wr_strobe, flash_abort, dev_reset;
  int n_fail = 0, n_tests = 0, n_pulse = 0, n_wr = 0, cyc = 0, seed = 19206;
  always #20 mclk = ~mclk;
  mbpi_host host (.mclk, .dev_lo(lo_o), .dev_lo_oe(lo_oe), .lo_pin, .hi_pin, .wr_pin, .rd_pin, .as_pin);
  mbpi_top DUT (.mclk, .rst, .reset_n, .low_addr_data_port_i(lo_pin), .low_addr_data_port_o(lo_o),
    .low_addr_data_port_oe(lo_oe), .high_addr_data_port_i(hi_pin), .high_addr_data_port_o(hi_o),
    .high_addr_data_port_oe(hi_oe), .write_control_pin(wr_pin), .read_control_pin(rd_pin),
    .fetch_select_pin(fpin), .address_valid_strobe(as_pin), .host_type, .as_rising, .fetch_is_strobe,
    .block_select, .rd_data, .rd_data_hi, .wide_bus, .flash_busy, .pla_addr, .pla_write_ctl, .pla_read_ctl,
    .pla_fetch_n, .pla_general_in, .pla_rd_cycle, .pla_wr_cycle, .wr_data, .wr_strobe, .flash_abort, .dev_reset);
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // counted away from the launching edge, so no race with the pulse
  always @(negedge mclk) if (wr_strobe === 1'b1) n_pulse++;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      results();
    end
  end
  task automatic start(input logic [1:0] t, input logic rise, input logic fs);
    {rst, reset_n, host_type, as_rising, fetch_is_strobe} = {2'h2, t, rise, fs};
    host.idle(t);
    fpin = fs ? 1'b1 : 1'($random(seed));
    repeat (6) @(posedge mclk);
    #2 {rst, reset_n} = 2'h1;
    repeat (8) @(posedge mclk);
    #2 check("dev_reset", dev_reset, 0);
    check("general_in", pla_general_in, fs ? 1'b0 : fpin);
    check("fetch_n", pla_fetch_n, 1);
  endtask
  // k: 1 read, 2 write
  task automatic op(input int k, input logic [15:0] a, input logic [7:0] d, input logic sel);
    {block_select, rd_data, rd_data_hi, wide_bus} = {sel, d, ~d, a[0]};
    fork
      host.bus(host_type, a, k, d);
      begin
        repeat (15) @(posedge mclk);
        #1 check("rd_cycle", pla_rd_cycle, k == 1);
        check("wr_cycle", pla_wr_cycle, k == 2);
        check("lo_oe", lo_oe, k == 1 && sel);
        check("hi_oe", hi_oe, k == 1 && sel && a[0]);
        if (hi_oe === 1'b1) check("hi_o", {hi_o, lo_o}, {~d, d});
        check("read_ctl", pla_read_ctl, rd_pin);
      end
    join
    check("addr", pla_addr, a);
    if (k == 2) begin
      n_wr++;
      // strobe comes one cycle after the qualifier drops
      repeat (3) @(posedge mclk);
      #2 check("wr_data", wr_data, d);
    end
    check("wr_pulses", n_pulse, n_wr);
  endtask
  initial begin
    for (int t = 0; t < 4; t++) begin
      start(t[1:0], t[0], t == 3);
      for (int i = 0; i < 5; i++) begin
        a = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
        op(1, a, 8'($random(seed)), 1'b1);
        op(1, ~a, 8'($random(seed)), 1'b0);
        op(2, a ^ 16'h5a5a, 8'($random(seed)), i[0]);
      end
      if (t == 3) begin
        // fetch strobe acts as a read in fetch mode
        @(posedge mclk) #2 fpin = 1'b0;
        repeat (4) @(posedge mclk);
        #2 check("fetch_rd", pla_rd_cycle, 1);
        check("fetch_lo", pla_fetch_n, 0);
        fpin = 1'b1;
        repeat (4) @(posedge mclk);
        #2 check("fetch_end", pla_rd_cycle, 0);
      end
      $display("host type %0d done, mismatches %0d", t, n_fail);
    end
    // reset pin during a flash operation
    @(posedge mclk) #2 {flash_busy, reset_n} = 2'h2;
    repeat (6) @(posedge mclk);
    #1 check("abort", flash_abort, 1);
    check("rst_addr", pla_addr, 0);
    check("rst_dev", dev_reset, 1);
    @(posedge mclk) #2 {flash_busy, reset_n} = 2'h3;
    repeat (6) @(posedge mclk);
    #1 check("abort_off", flash_abort, 0);
    $display("reset test done, mismatches %0d", n_fail);
    results();
  end
endmodule // testbench
